// ### pkg/pws_consts.vh
`ifndef PWS_CONSTS_VH
`define PWS_CONSTS_VH

// Watchdog expiry of 250 ms at a 25 MHz clock, in clock cycles
`define PWS_WDT_CYCLES      24'd6250000
// Processor reset pulse of 100 us and recovery wait of 250 ms, in clock cycles
`define PWS_RST_PULSE_CYC   24'd2500
`define PWS_RECOVER_CYC     24'd6250000
`define PWS_CNT_W           24

// Nonvolatile store geometry
`define PWS_NV_DEPTH        64
`define PWS_NV_AW           6
`define PWS_NV_DW           8
`define PWS_NV_RESET        8'h00

// Setting locations (protected by the lockout); trip capture above
`define PWS_SET_LAST        6'h1f

`endif

// ### hdl/pws_supervisor.v
// Contract
// - Reset processor after 0.25 s without pulse
// - Block store writes from expiry until processor recovers
// - Stuck processor drops relays and healthy LED
// - Supply low raises power-fail interrupt
// - Store holds 64 locations of 8 bits
// - Hysteresis holds off until supply good
// - Setting writes need lockout input closed
`timescale 1ns/1ps
`include "pws_consts.vh"

module pws_supervisor #(
  parameter [`PWS_CNT_W-1:0] WDT_CYCLES  = `PWS_WDT_CYCLES,
  parameter [`PWS_CNT_W-1:0] RST_CYCLES  = `PWS_RST_PULSE_CYC,
  parameter [`PWS_CNT_W-1:0] RECOV_CYCLES = `PWS_RECOVER_CYC
) (
  input  wire                   CLK_I,
  input  wire                   RST_N_I,
  input  wire                   WDT_PULSE_I,
  input  wire                   CPU_ALIVE_I,
  input  wire                   SUPPLY_BELOW_MIN_I,
  input  wire                   SUPPLY_IN_SPEC_I,
  input  wire                   LOCKOUT_CLOSED_I,
  input  wire                   NV_WR_I,
  input  wire [`PWS_NV_AW-1:0]  NV_ADDR_I,
  input  wire [`PWS_NV_DW-1:0]  NV_WDATA_I,
  output reg  [`PWS_NV_DW-1:0]  NV_RDATA_O,
  output reg                    NV_WR_DONE_O,
  output reg                    NV_WR_REFUSED_O,
  output reg                    CPU_RST_N_O,
  output reg                    PFAIL_IRQ_O,
  output reg                    RUN_EN_O,
  output reg                    TRIP_RELAY_EN_O,
  output reg                    ALARM_RELAY_EN_O,
  output reg                    HEALTHY_LED_O,
  output reg                    WDT_EXPIRED_O
);

  // Watchdog states
  localparam [1:0] ST_WATCH   = 2'd0;
  localparam [1:0] ST_RESET   = 2'd1;
  localparam [1:0] ST_RECOVER = 2'd2;
  localparam [1:0] ST_FAILED  = 2'd3;

  reg [1:0]            state_q;
  reg [`PWS_CNT_W-1:0] cnt_q;
  reg                  pulse_q;
  reg                  nv_lock_q;
  reg                  pf_q;
  reg [`PWS_NV_DW-1:0] nv_mem_q [0:`PWS_NV_DEPTH-1];
  integer              i;

  // Counter has spent its limit of cycles
  function cnt_hit;
    input [`PWS_CNT_W-1:0] cnt;
    input [`PWS_CNT_W-1:0] limit;
    begin
      cnt_hit = (cnt >= limit - {{(`PWS_CNT_W-1){1'b0}}, 1'b1});
    end
  endfunction

  // Counter step, kept at counter width
  function [`PWS_CNT_W-1:0] cnt_inc;
    input [`PWS_CNT_W-1:0] cnt;
    begin
      cnt_inc = cnt + {{(`PWS_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Low part of the store holds settings, guarded by the lockout
  function addr_is_setting;
    input [`PWS_NV_AW-1:0] addr;
    begin
      addr_is_setting = (addr <= `PWS_SET_LAST);
    end
  endfunction

  function write_allowed;
    input wr;
    input locked;
    input setting;
    input lockout;
    begin
      write_allowed = wr & ~locked & (~setting | lockout);
    end
  endfunction

  wire pulse_rise = WDT_PULSE_I & ~pulse_q;
  wire is_setting = addr_is_setting(NV_ADDR_I);
  wire wr_ok      = write_allowed(NV_WR_I, nv_lock_q, is_setting, LOCKOUT_CLOSED_I);

  // Previous pulse level, for edge detection
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= WDT_PULSE_I;
    end
  end

  // Watchdog sequence: watch, reset pulse, wait for recovery, failed
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q          <= ST_WATCH;
      cnt_q            <= {`PWS_CNT_W{1'b0}};
      nv_lock_q        <= 1'b0;
      CPU_RST_N_O      <= 1'b0;
      TRIP_RELAY_EN_O  <= 1'b0;
      ALARM_RELAY_EN_O <= 1'b0;
      HEALTHY_LED_O    <= 1'b0;
      WDT_EXPIRED_O    <= 1'b0;
    end else begin
      case (state_q)
        ST_WATCH: begin
          CPU_RST_N_O      <= 1'b1;
          TRIP_RELAY_EN_O  <= 1'b1;
          ALARM_RELAY_EN_O <= 1'b1;
          HEALTHY_LED_O    <= 1'b1;
          if (pulse_rise) begin
            cnt_q <= {`PWS_CNT_W{1'b0}};
          end else if (cnt_hit(cnt_q, WDT_CYCLES)) begin
            state_q       <= ST_RESET;
            cnt_q         <= {`PWS_CNT_W{1'b0}};
            CPU_RST_N_O   <= 1'b0;
            nv_lock_q     <= 1'b1;
            WDT_EXPIRED_O <= 1'b1;
          end else begin
            cnt_q <= cnt_inc(cnt_q);
          end
        end
        ST_RESET: begin
          CPU_RST_N_O <= 1'b0;
          if (cnt_hit(cnt_q, RST_CYCLES)) begin
            state_q     <= ST_RECOVER;
            cnt_q       <= {`PWS_CNT_W{1'b0}};
            CPU_RST_N_O <= 1'b1;
          end else begin
            cnt_q <= cnt_inc(cnt_q);
          end
        end
        ST_RECOVER: begin
          // Processor confirmed out of reset releases the store lock
          if (CPU_ALIVE_I & pulse_rise) begin
            state_q       <= ST_WATCH;
            cnt_q         <= {`PWS_CNT_W{1'b0}};
            nv_lock_q     <= 1'b0;
            WDT_EXPIRED_O <= 1'b0;
          end else if (cnt_hit(cnt_q, RECOV_CYCLES)) begin
            state_q          <= ST_FAILED;
            TRIP_RELAY_EN_O  <= 1'b0;
            ALARM_RELAY_EN_O <= 1'b0;
            HEALTHY_LED_O    <= 1'b0;
          end else begin
            cnt_q <= cnt_inc(cnt_q);
          end
        end
        ST_FAILED: begin
          TRIP_RELAY_EN_O  <= 1'b0;
          ALARM_RELAY_EN_O <= 1'b0;
          HEALTHY_LED_O    <= 1'b0;
          if (CPU_ALIVE_I & pulse_rise) begin
            state_q       <= ST_WATCH;
            cnt_q         <= {`PWS_CNT_W{1'b0}};
            nv_lock_q     <= 1'b0;
            WDT_EXPIRED_O <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_WATCH;
          cnt_q   <= {`PWS_CNT_W{1'b0}};
        end
      endcase
    end
  end

  // Power-fail latch with hysteresis between the two thresholds
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pf_q <= 1'b1;
    end else if (SUPPLY_BELOW_MIN_I) begin
      pf_q <= 1'b1;
    end else if (SUPPLY_IN_SPEC_I) begin
      pf_q <= 1'b0;
    end
  end

  // Interrupt on entry into power fail; run enable only with supply good
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PFAIL_IRQ_O <= 1'b0;
      RUN_EN_O    <= 1'b0;
    end else begin
      PFAIL_IRQ_O <= SUPPLY_BELOW_MIN_I & ~pf_q;
      RUN_EN_O    <= ~pf_q & ~SUPPLY_BELOW_MIN_I;
    end
  end

  // Nonvolatile store, writable for the save even after power fail
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      for (i = 0; i < `PWS_NV_DEPTH; i = i + 1) begin
        nv_mem_q[i] <= `PWS_NV_RESET;
      end
    end else if (wr_ok) begin
      nv_mem_q[NV_ADDR_I] <= NV_WDATA_I;
    end
  end

  // Read data and write status, one cycle after the request
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      NV_RDATA_O      <= `PWS_NV_RESET;
      NV_WR_DONE_O    <= 1'b0;
      NV_WR_REFUSED_O <= 1'b0;
    end else begin
      NV_RDATA_O      <= nv_mem_q[NV_ADDR_I];
      NV_WR_DONE_O    <= wr_ok;
      NV_WR_REFUSED_O <= NV_WR_I & ~wr_ok;
    end
  end

endmodule

// ### verification/pws_props.sv
`timescale 1ns/1ps
module pws_props (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire       WDT_PULSE_I,
  input wire       SUPPLY_BELOW_MIN_I,
  input wire       SUPPLY_IN_SPEC_I,
  input wire       LOCKOUT_CLOSED_I,
  input wire       NV_WR_I,
  input wire       CPU_RST_N_O,
  input wire       PFAIL_IRQ_O,
  input wire       RUN_EN_O,
  input wire       TRIP_RELAY_EN_O,
  input wire       ALARM_RELAY_EN_O,
  input wire       HEALTHY_LED_O,
  input wire       WDT_EXPIRED_O,
  input wire       NV_WR_DONE_O,
  input wire       NV_WR_REFUSED_O,
  input wire [5:0] NV_ADDR_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_free; NV_WR_I && !WDT_EXPIRED_O && NV_ADDR_I[5]; endsequence
  sequence s_set; NV_WR_I && !LOCKOUT_CLOSED_I && !NV_ADDR_I[5]; endsequence
  sequence s_beat; $rose(WDT_PULSE_I) && !WDT_EXPIRED_O; endsequence
  sequence s_low; !SUPPLY_IN_SPEC_I [*3] ##0 !RUN_EN_O; endsequence
  a_store_write: assert property (s_free |=> NV_WR_DONE_O)
    else $error("free write lost");
  a_lockout_gate: assert property (s_set |=> NV_WR_REFUSED_O)
    else $error("locked write taken");
  a_expired_lock: assert property (NV_WR_I && WDT_EXPIRED_O |=> NV_WR_REFUSED_O)
    else $error("store not locked");
  a_expiry_reset: assert property ($rose(WDT_EXPIRED_O) |-> !CPU_RST_N_O)
    else $error("no cpu reset");
  a_pulse_restart: assert property (s_beat |=> !WDT_EXPIRED_O)
    else $error("pulse ignored");
  a_pfail_irq: assert property (SUPPLY_BELOW_MIN_I && RUN_EN_O |=> PFAIL_IRQ_O)
    else $error("no power fail irq");
  a_run_holdoff: assert property (s_low |=> !RUN_EN_O)
    else $error("ran on bad supply");
  a_stuck_outputs: assert property ($fell(TRIP_RELAY_EN_O) |-> WDT_EXPIRED_O
                                    && !ALARM_RELAY_EN_O && !HEALTHY_LED_O)
    else $error("relays out of step");
endmodule
bind pws_supervisor pws_props u_props (.*);

// ### verification/pws_cpu_model.sv
`timescale 1ns/1ps
module pws_cpu_model (
  input  wire clk_i,
  input  wire run_i,
  input  wire cpu_rst_n_i,
  output reg  pulse_o = 1'b0,
  output reg  alive_o = 1'b0
);
  reg [2:0] cnt_q = 3'h0;
  // A stopped or held core stays silent
  always @(posedge clk_i) begin
    cnt_q   <= cnt_q + 3'h1;
    pulse_o <= run_i && cpu_rst_n_i && cnt_q == 3'h0;
    alive_o <= run_i && cpu_rst_n_i;
  end
endmodule

// ### verification/processor_watchdog_supervisor_test.sv
`timescale 1ns/1ps
module processor_watchdog_supervisor_test;
  reg clk = 0, rst_n = 0, run = 1, below = 0, spec = 0, lock = 0, wr = 0;
  reg     [5:0] addr = 6'h00;
  reg     [7:0] wdata = 8'h00;
  reg     [5:0] ra;
  wire    [7:0] rdata;
  wire          pulse, alive, done, refused, crst_n, irq, run_en, trip, alarm, led, expired;
  integer       err_total = 0, n_checks = 0, i;
  initial forever #20 clk = ~clk;
  pws_cpu_model cpu_u (.clk_i(clk), .run_i(run), .cpu_rst_n_i(crst_n), .pulse_o(pulse),
    .alive_o(alive));
  pws_supervisor #(.WDT_CYCLES(24'd20), .RST_CYCLES(24'd4), .RECOV_CYCLES(24'd10)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .WDT_PULSE_I(pulse), .CPU_ALIVE_I(alive),
    .SUPPLY_BELOW_MIN_I(below), .SUPPLY_IN_SPEC_I(spec), .LOCKOUT_CLOSED_I(lock), .NV_WR_I(wr),
    .NV_ADDR_I(addr), .NV_WDATA_I(wdata), .NV_RDATA_O(rdata), .NV_WR_DONE_O(done),
    .NV_WR_REFUSED_O(refused), .CPU_RST_N_O(crst_n), .PFAIL_IRQ_O(irq), .RUN_EN_O(run_en),
    .TRIP_RELAY_EN_O(trip), .ALARM_RELAY_EN_O(alarm), .HEALTHY_LED_O(led),
    .WDT_EXPIRED_O(expired));
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0s exp %h got %h", nm, exp, got);
    end
  endtask
  // Write accepted unless the watchdog has expired or a setting is locked
  function exp_ok(input [5:0] a, input lk, input xp);
    exp_ok = !xp && (a[5] || lk);
  endfunction
  task print_verdict;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wrt(input [5:0] a, input [7:0] d, input ok);
    @(posedge clk) begin
      wr <= 1'b1; addr <= a; wdata <= d;
    end
    @(posedge clk) wr <= 1'b0;
    #1 chk("done", ok, done);
    chk("refused", !ok, refused);
    @(posedge clk) #1 if (ok) chk("rdata", d, rdata);
  endtask
  task wexp(input v);
    i = 0;
    while (expired !== v && i < 30) begin
      @(posedge clk) #1 i = i + 1;
    end
    if (expired !== v) begin
      chk("timeout", v, expired);
      print_verdict;
    end
  endtask
  initial begin
    i = $urandom(32'he130);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("run_en", 0, run_en);
    @(posedge clk) spec <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("run_en", 1, run_en);
    @(posedge clk) below <= 1'b1;
    @(posedge clk) below <= 1'b0;
    #1 chk("irq", 1, irq);
    wrt(6'h3f, 8'hc3, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      ra = $urandom;
      wrt(ra, 8'($urandom), exp_ok(ra, lock, 1'b0));
    end
    for (i = 0; i < 6; i = i + 1) wrt({1'b1, 5'($urandom)}, 8'($urandom), 1'b1);
    wrt(6'h1f, 8'h5a, 1'b0);
    @(posedge clk) lock <= 1'b1;
    wrt(6'h00, 8'ha5, 1'b1);
    repeat (30) @(posedge clk);
    #1 chk("expired", 0, expired);
    @(posedge clk) run <= 1'b0;
    wexp(1'b1);
    chk("late", 1, i > 9);
    chk("cpu_rst_n", 0, crst_n);
    wrt(6'h20, 8'h11, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk("trip", 0, trip);
    chk("alarm", 0, alarm);
    chk("led", 0, led);
    @(posedge clk) run <= 1'b1;
    wexp(1'b0);
    @(posedge clk) #1 chk("trip", 1, trip);
    print_verdict;
  end
endmodule
